// ===== src/lpm_params.svh
// Offsets, field positions, reset values and divider width of the low-power controller
`ifndef LPM_PARAMS_SVH
`define LPM_PARAMS_SVH

// Register offsets (byte addresses, one word each)
`define LPM_OFF_STANDBY 8'h00
`define LPM_OFF_STOP_A 8'h04
`define LPM_OFF_STOP_B 8'h08
`define LPM_OFF_STOP_C 8'h0c
`define LPM_OFF_STOP_D 8'h10
`define LPM_OFF_DIV_CORE 8'h14
`define LPM_OFF_DIV_PER 8'h18
`define LPM_OFF_STATUS 8'h1c

// Standby control fields
`define LPM_MODE_LSB 0
`define LPM_MODE_MSB 1

// Module stop bit positions
`define LPM_STOP_CMTW1 0
`define LPM_STOP_CMTW0 1
`define LPM_STOP_MTMR 9
`define LPM_STOP_SER11 24
`define LPM_STOP_SER9 26
`define LPM_STOP_SER8 27
`define LPM_STOP_D5 5
`define LPM_STOP_CANFD 10
`define LPM_STOP_SPI0 26

// Reset values
`define LPM_RST_STANDBY 16'h0000
`define LPM_RST_STOP 32'hffff_ffff
`define LPM_RST_DIV 32'h0000_0000

// Divider field width
`define LPM_DIV_W 4

`endif

// ===== src/lpm_pkg.sv
// Types of the low-power controller
package lpm_pkg;

  typedef enum logic [1:0] {
    MODE_SLEEP,
    MODE_ALL_STOP,
    MODE_SW_STANDBY,
    MODE_RSVD
  } lp_mode_t;

  typedef enum logic [1:0] {
    ST_RUN,
    ST_SLEEP,
    ST_ALL_STOP,
    ST_STANDBY
  } lp_state_t;

endpackage

// ===== src/clk_div_enable.sv
// Programmable divider that yields a one-cycle enable pulse
`include "lpm_params.svh"

module clk_div_enable
(
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // Control
  input wire logic i_run,
  input wire logic [`LPM_DIV_W-1:0] i_ratio_log2,
  // Enable out
  output logic o_en
);

  logic [14:0] count_reg;
  logic [14:0] limit;

  // ----------------------------------------
  // Divide by two to the power of the ratio
  // ----------------------------------------
  assign limit = 15'((16'h1 << i_ratio_log2) - 16'h1);

  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      count_reg <= 15'h0000;
      o_en <= 1'b0;
    end
    else if (!i_run)
    begin
      o_en <= 1'b0;
    end
    else if (count_reg >= limit)
    begin
      count_reg <= 15'h0000;
      o_en <= 1'b1;
    end
    else
    begin
      count_reg <= count_reg + 15'h0001;
      o_en <= 1'b0;
    end
  end

endmodule // clk_div_enable

// ===== src/low_power_mode_controller.sv
// Low-power mode controller with clock dividers and module stop gating
`include "lpm_params.svh"

// How it works
// - Independent dividers for core, four peripheral, flash
// - One stop bit halts one module only
// - Sleep, all-module stop, software standby modes
// - Mode chosen in register, entered on wait
// - Only interrupt or reset leaves a mode
// - Wake hands CPU the waking interrupt
// - Standby stops oscillators and PLL, not watchdog
// - Independent watchdog runs; ordinary watchdog frozen
// - Eight-bit timers run except in standby
// - Output enable logic frozen in standby only
// - Frozen units keep their registers unchanged
// - Runnable units follow their own control
// - Stop bit: zero releases, one stops
// - Stop A: bit0 unit1, bit1 unit0, bit9
// - Stop D bit5 gates I3C unit 0
// - Stop D bit10 gates CAN FD
// - Stop D bit26 gates SPI unit 0
// - Stop C bits 24, 26, 27 serial
module low_power_mode_controller
#(
  parameter int NUM_MOD = 32
)
(
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // Register port
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  // CPU and interrupt controller
  input wire logic i_wait_insn,
  input wire logic i_irq_req,
  input wire logic [7:0] i_irq_vector,
  output logic o_cpu_halt,
  output logic o_wake,
  output logic [7:0] o_wake_vector,
  output logic [2:0] o_mode_state,
  // Unit own enables
  input wire logic i_independent_watchdog_run,
  input wire logic i_tmr_run,
  input wire logic i_poe_run,
  // Clock enables
  output logic o_en_core,
  output logic o_en_per_fast,
  output logic o_en_per_gen,
  output logic o_en_counter,
  output logic o_en_analog,
  output logic o_en_flash,
  // Unit gating
  output logic [NUM_MOD-1:0] o_stop_a,
  output logic [NUM_MOD-1:0] o_stop_b,
  output logic [NUM_MOD-1:0] o_stop_c,
  output logic [NUM_MOD-1:0] o_stop_d,
  output logic o_osc_run,
  output logic o_independent_watchdog_osc_run,
  output logic o_independent_watchdog_en,
  output logic o_wdt_en,
  output logic o_tmr_en,
  output logic o_poe_en,
  output logic o_mem_en,
  output logic o_port_hold
);

  if (NUM_MOD != 32)
  begin : gen_bad_width
    $error("NUM_MOD must be 32");
  end

  logic [15:0] standby_control_reg;
  logic [31:0] module_stop_control_a_reg;
  logic [31:0] module_stop_control_b_reg;
  logic [31:0] module_stop_control_c_reg;
  logic [31:0] module_stop_control_d_reg;
  logic [31:0] div_core_reg;
  logic [31:0] div_per_reg;
  lpm_pkg::lp_state_t state_reg;
  lpm_pkg::lp_state_t state_next;
  lpm_pkg::lp_mode_t sel_mode;
  logic [5:0] div_en;
  logic run_core;
  logic run_per;
  logic run_flash;

  function automatic logic [3:0] nib(input logic [31:0] w, input int idx);
    nib = w[idx*4 +: 4];
  endfunction

  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      standby_control_reg <= `LPM_RST_STANDBY;
      module_stop_control_a_reg <= `LPM_RST_STOP;
      module_stop_control_b_reg <= `LPM_RST_STOP;
      module_stop_control_c_reg <= `LPM_RST_STOP;
      module_stop_control_d_reg <= `LPM_RST_STOP;
      div_core_reg <= `LPM_RST_DIV;
      div_per_reg <= `LPM_RST_DIV;
    end
    else if (i_wr)
    begin
      unique case (i_addr)
        `LPM_OFF_STANDBY: standby_control_reg <= i_wdata[15:0];
        `LPM_OFF_STOP_A: module_stop_control_a_reg <= i_wdata;
        `LPM_OFF_STOP_B: module_stop_control_b_reg <= i_wdata;
        `LPM_OFF_STOP_C: module_stop_control_c_reg <= i_wdata;
        `LPM_OFF_STOP_D: module_stop_control_d_reg <= i_wdata;
        `LPM_OFF_DIV_CORE: div_core_reg <= i_wdata;
        `LPM_OFF_DIV_PER: div_per_reg <= i_wdata;
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // Register reads
  // ----------------------------------------
  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_rdata <= 32'h0000_0000;
    else if (i_rd)
    begin
      unique case (i_addr)
        `LPM_OFF_STANDBY: o_rdata <= {16'h0000, standby_control_reg};
        `LPM_OFF_STOP_A: o_rdata <= module_stop_control_a_reg;
        `LPM_OFF_STOP_B: o_rdata <= module_stop_control_b_reg;
        `LPM_OFF_STOP_C: o_rdata <= module_stop_control_c_reg;
        `LPM_OFF_STOP_D: o_rdata <= module_stop_control_d_reg;
        `LPM_OFF_DIV_CORE: o_rdata <= div_core_reg;
        `LPM_OFF_DIV_PER: o_rdata <= div_per_reg;
        `LPM_OFF_STATUS: o_rdata <= {30'h0000_0000, state_reg};
        default: o_rdata <= 32'h0000_0000;
      endcase
    end
    else
      o_rdata <= 32'h0000_0000;
  end

  // ----------------------------------------
  // Mode sequencer
  // ----------------------------------------
  assign sel_mode = lpm_pkg::lp_mode_t'(standby_control_reg[`LPM_MODE_MSB:`LPM_MODE_LSB]);

  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      lpm_pkg::ST_RUN:
        if (i_wait_insn)
        begin
          unique case (sel_mode)
            lpm_pkg::MODE_SLEEP: state_next = lpm_pkg::ST_SLEEP;
            lpm_pkg::MODE_ALL_STOP: state_next = lpm_pkg::ST_ALL_STOP;
            lpm_pkg::MODE_SW_STANDBY: state_next = lpm_pkg::ST_STANDBY;
            default: state_next = lpm_pkg::ST_SLEEP;
          endcase
        end
      lpm_pkg::ST_SLEEP,
      lpm_pkg::ST_ALL_STOP,
      lpm_pkg::ST_STANDBY:
        if (i_irq_req)
          state_next = lpm_pkg::ST_RUN;
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      state_reg <= lpm_pkg::ST_RUN;
    else
      state_reg <= state_next;
  end

  // Wake pulse with the waking vector
  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_wake <= 1'b0;
      o_wake_vector <= 8'h00;
    end
    else
    begin
      o_wake <= (state_reg != lpm_pkg::ST_RUN) && i_irq_req;
      if ((state_reg != lpm_pkg::ST_RUN) && i_irq_req)
        o_wake_vector <= i_irq_vector;
    end
  end

  // ----------------------------------------
  // Clock dividers
  // ----------------------------------------
  assign run_core = (state_next == lpm_pkg::ST_RUN);
  assign run_per = (state_next == lpm_pkg::ST_RUN) || (state_next == lpm_pkg::ST_SLEEP);
  assign run_flash = run_per;

  genvar g;
  generate
    for (g = 0; g < 6; g++)
    begin : gen_div
      clk_div_enable u_div
      (
        .i_mclk(i_mclk),
        .i_rst_n(i_rst_n),
        .i_run(g == 0 ? run_core : (g == 5 ? run_flash : run_per)),
        .i_ratio_log2(g < 4 ? nib(div_core_reg, g) : nib(div_per_reg, g - 4)),
        .o_en(div_en[g])
      );
    end
  endgenerate

  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_en_core <= 1'b0;
      o_en_per_fast <= 1'b0;
      o_en_per_gen <= 1'b0;
      o_en_counter <= 1'b0;
      o_en_analog <= 1'b0;
      o_en_flash <= 1'b0;
    end
    else
    begin
      o_en_core <= div_en[0] && run_core;
      o_en_per_fast <= div_en[1] && run_per;
      o_en_per_gen <= div_en[2] && run_per;
      o_en_counter <= div_en[3] && run_per;
      o_en_analog <= div_en[4] && run_per;
      o_en_flash <= div_en[5] && run_flash;
    end
  end

  // ----------------------------------------
  // Module and unit gating
  // ----------------------------------------
  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_stop_a <= `LPM_RST_STOP;
      o_stop_b <= `LPM_RST_STOP;
      o_stop_c <= `LPM_RST_STOP;
      o_stop_d <= `LPM_RST_STOP;
    end
    else
    begin
      // One per module, 1 stops, 0 releases; frozen with state kept in deeper modes
      o_stop_a <= module_stop_control_a_reg | {NUM_MOD{!run_per}};
      o_stop_b <= module_stop_control_b_reg | {NUM_MOD{!run_per}};
      o_stop_c <= module_stop_control_c_reg | {NUM_MOD{!run_per}};
      o_stop_d <= module_stop_control_d_reg | {NUM_MOD{!run_per}};
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_osc_run <= 1'b1;
      o_independent_watchdog_osc_run <= 1'b1;
      o_independent_watchdog_en <= 1'b0;
      o_wdt_en <= 1'b0;
      o_tmr_en <= 1'b0;
      o_poe_en <= 1'b0;
      o_mem_en <= 1'b1;
      o_port_hold <= 1'b0;
      o_cpu_halt <= 1'b0;
      o_mode_state <= 3'h0;
    end
    else
    begin
      o_osc_run <= state_next != lpm_pkg::ST_STANDBY;
      o_independent_watchdog_osc_run <= 1'b1;
      o_independent_watchdog_en <= i_independent_watchdog_run;
      o_wdt_en <= run_core;
      o_tmr_en <= i_tmr_run && (state_next != lpm_pkg::ST_STANDBY);
      o_poe_en <= i_poe_run && (state_next != lpm_pkg::ST_STANDBY);
      o_mem_en <= run_per;
      o_port_hold <= !run_per;
      o_cpu_halt <= !run_core;
      o_mode_state <= {1'b0, state_next};
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  enter_on_wait_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (state_reg == lpm_pkg::ST_RUN && !i_wait_insn) |=> state_reg == lpm_pkg::ST_RUN)
    else $error("Mode entered without wait");

  leave_on_irq_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (state_reg != lpm_pkg::ST_RUN && !i_irq_req) |=> state_reg == $past(state_reg))
    else $error("Mode left without interrupt");

  wake_vector_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (state_reg != lpm_pkg::ST_RUN && i_irq_req) |=> o_wake && o_wake_vector == $past(i_irq_vector))
    else $error("Wake vector wrong");

  standby_osc_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    state_reg == lpm_pkg::ST_STANDBY |-> !o_osc_run && o_independent_watchdog_osc_run)
    else $error("Oscillator running in standby");

  wdt_frozen_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    state_reg != lpm_pkg::ST_RUN |-> !o_wdt_en)
    else $error("Watchdog running in low power");

  timer_standby_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    state_reg == lpm_pkg::ST_STANDBY |-> !o_tmr_en && !o_poe_en)
    else $error("Timer running in standby");

  sleep_cpu_only_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    state_reg == lpm_pkg::ST_SLEEP |-> o_cpu_halt && o_mem_en && !o_port_hold)
    else $error("Sleep halted too much");

  deep_hold_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    state_reg == lpm_pkg::ST_ALL_STOP |-> !o_mem_en && o_port_hold && (&o_stop_a))
    else $error("All-stop not held");

  stop_bit_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (state_reg == lpm_pkg::ST_RUN && state_next == lpm_pkg::ST_RUN)
    |=> o_stop_c == $past(module_stop_control_c_reg))
    else $error("Stop bit not followed");

  core_gate_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    o_cpu_halt |-> !o_en_core)
    else $error("Core enable while halted");

endmodule // low_power_mode_controller

// ===== test/cpu_irq_model.sv
// CPU core and interrupt controller model facing the low-power controller
module cpu_irq_model
(
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // Bench commands
  input wire logic i_go,
  input wire logic i_stray,
  input wire logic [7:0] i_delay,
  input wire logic [7:0] i_vec,
  // Controller side
  input wire logic i_halt,
  input wire logic i_wake,
  output logic o_wait_insn,
  output logic o_irq_req,
  output logic [7:0] o_irq_vector
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt_reg;
  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_wait_insn <= 1'b0;
      o_irq_req <= 1'b0;
      o_irq_vector <= 8'h00;
      cnt_reg <= 8'h00;
    end
    else
    begin
      o_wait_insn <= i_go;
      if (i_wake || !i_halt)
      begin
        o_irq_req <= i_stray;
        o_irq_vector <= ~o_irq_vector;
        cnt_reg <= 8'h00;
      end
      else if (cnt_reg == i_delay)
      begin
        o_irq_req <= 1'b1;
        o_irq_vector <= i_vec;
      end
      else
        cnt_reg <= cnt_reg + 8'h01;
    end
  end
endmodule // cpu_irq_model

// ===== test/test_low_power_mode_controller.sv
// Self-checking bench of the low-power mode controller
`include "lpm_params.svh"
module test_low_power_mode_controller;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_mclk, i_rst_n, i_wr, i_rd, go, stray, i_wait_insn, i_irq_req, o_cpu_halt, o_wake;
  logic [7:0] i_addr, delay, vec, i_irq_vector, o_wake_vector;
  logic [31:0] i_wdata, o_rdata, rv, o_stop_a, o_stop_b, o_stop_c, o_stop_d;
  logic [2:0] o_mode_state;
  logic i_independent_watchdog_run, i_tmr_run, i_poe_run, o_osc_run, o_independent_watchdog_osc_run, o_independent_watchdog_en, o_wdt_en;
  logic o_en_core, o_en_per_fast, o_en_per_gen, o_en_counter, o_en_analog, o_en_flash;
  logic o_tmr_en, o_poe_en, o_mem_en, o_port_hold;
  wire logic [127:0] stops = {o_stop_d, o_stop_c, o_stop_b, o_stop_a};
  int n_errors = 0;
  int total_checks = 0;
  int cycles = 0;
  low_power_mode_controller i_low_power_mode_controller (.i_mclk, .i_rst_n, .i_addr,
    .i_wdata, .i_wr, .i_rd, .o_rdata, .i_wait_insn, .i_irq_req, .i_irq_vector, .o_cpu_halt,
    .o_wake, .o_wake_vector, .o_mode_state, .i_independent_watchdog_run, .i_tmr_run, .i_poe_run, .o_en_core,
    .o_en_per_fast, .o_en_per_gen, .o_en_counter, .o_en_analog, .o_en_flash, .o_stop_a,
    .o_stop_b, .o_stop_c, .o_stop_d, .o_osc_run, .o_independent_watchdog_osc_run, .o_independent_watchdog_en, .o_wdt_en,
    .o_tmr_en, .o_poe_en, .o_mem_en, .o_port_hold);
  cpu_irq_model i_cpu_irq_model (.i_mclk, .i_rst_n, .i_go(go), .i_stray(stray),
    .i_delay(delay), .i_vec(vec), .i_halt(o_cpu_halt), .i_wake(o_wake),
    .o_wait_insn(i_wait_insn), .o_irq_req(i_irq_req), .o_irq_vector(i_irq_vector));
  // ----------------
  // Shared tasks
  // ----------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_mclk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask
  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge i_mclk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    @(negedge i_mclk);
    d = o_rdata;
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // ----------------
  // Scenarios
  // ----------------
  task automatic t_reset;
    for (int k = 0; k < 7; k++)
    begin
      reg_rd(8'(4 * k), rv);
      check(rv, (k == 0) ? 32'h0 : (k < 5) ? `LPM_RST_STOP : `LPM_RST_DIV);
    end
    reg_wr(8'h20, 32'h0000_0000);
    reg_rd(8'h20, rv);
    check(rv, 32'h0000_0000);
    check(stops[31:0] & stops[127:96], 32'hffff_ffff);
    $display("reset test done");
  endtask
  task automatic t_stop;
    int rg[9] = '{0, 0, 0, 2, 2, 2, 3, 3, 3};
    int bt[9] = '{`LPM_STOP_CMTW1, `LPM_STOP_CMTW0, `LPM_STOP_MTMR, `LPM_STOP_SER11,
      `LPM_STOP_SER9, `LPM_STOP_SER8, `LPM_STOP_D5, `LPM_STOP_CANFD, `LPM_STOP_SPI0};
    for (int t = 0; t < 9; t++)
    begin
      reg_wr(8'(`LPM_OFF_STOP_A + 4 * rg[t]), ~(32'h1 << bt[t]));
      repeat (2) @(negedge i_mclk);
      for (int k = 0; k < 4; k++)
        check(stops[k*32 +: 32], (k == rg[t]) ? ~(32'h1 << bt[t]) : 32'hffff_ffff);
      check(32'(stops[rg[t]*32 + bt[t]]), 32'h0);
      reg_wr(8'(`LPM_OFF_STOP_A + 4 * rg[t]), 32'hffff_ffff);
    end
    $display("stop test done");
  endtask
  task automatic t_div;
    logic [31:0] cnt[6] = '{default: 32'h0};
    reg_wr(`LPM_OFF_DIV_CORE, 32'h0000_3210);
    reg_wr(`LPM_OFF_DIV_PER, 32'h0000_0054);
    repeat (4) @(negedge i_mclk);
    repeat (64)
    begin
      @(negedge i_mclk);
      cnt[0] += o_en_core;
      cnt[1] += o_en_per_fast;
      cnt[2] += o_en_per_gen;
      cnt[3] += o_en_counter;
      cnt[4] += o_en_analog;
      cnt[5] += o_en_flash;
    end
    for (int k = 0; k < 6; k++)
      check(cnt[k], 64 >> k);
    $display("divider test done");
  endtask
  task automatic t_mode(input int m, input logic own);
    int st = (m == 3) ? 1 : m + 1;
    int n;
    reg_wr(`LPM_OFF_STANDBY, 32'(m));
    i_independent_watchdog_run <= own;
    i_tmr_run <= own;
    i_poe_run <= own;
    vec <= 8'h40 + 8'(m);
    @(negedge i_mclk);
    check(o_mode_state, 3'h0);
    @(posedge i_mclk);
    go <= 1'b1;
    @(posedge i_mclk);
    go <= 1'b0;
    for (n = 0; n < 10 && o_cpu_halt !== 1'b1; n++)
      @(negedge i_mclk);
    check(o_mode_state, 3'(st));
    check(o_cpu_halt, 1'b1);
    check({o_osc_run, o_independent_watchdog_osc_run, o_independent_watchdog_en, o_wdt_en}, {st != 3, 1'b1, own, 1'b0});
    check({o_tmr_en, o_poe_en}, {2{own && st != 3}});
    check({o_mem_en, o_port_hold, o_en_core}, {st == 1, st != 1, 1'b0});
    check(o_stop_a, (st == 1) ? 32'hffff_fffe : 32'hffff_ffff);
    for (n = 0; n < 20 && o_wake !== 1'b1; n++)
      @(negedge i_mclk);
    check(n >= 6, 1'b1);
    check({o_wake, o_wake_vector, o_cpu_halt, o_mode_state}, {1'b1, vec, 4'h0});
    @(negedge i_mclk);
    check(o_wake, 1'b0);
    reg_rd(`LPM_OFF_STOP_A, rv);
    check(rv & o_stop_a, 32'hffff_fffe);
    $display("mode %0d test done", m);
  endtask
  task automatic t_stray;
    stray <= 1'b1;
    repeat (4) @(negedge i_mclk);
    check({o_wake, o_cpu_halt, o_mode_state}, 5'h0);
    stray <= 1'b0;
    $display("stray interrupt test done");
  endtask
  task automatic t_reset_wake;
    delay <= 8'hc8;
    reg_wr(`LPM_OFF_STANDBY, 32'h2);
    go <= 1'b1;
    @(posedge i_mclk);
    go <= 1'b0;
    repeat (6) @(negedge i_mclk);
    check({o_mode_state, o_osc_run}, 4'h6);
    i_rst_n <= 1'b0;
    repeat (2) @(negedge i_mclk);
    check({o_mode_state, o_osc_run, o_cpu_halt}, 5'h2);
    i_rst_n <= 1'b1;
    $display("reset wake test done");
  endtask
  // ----------------
  // Clock, timeout, sequence
  // ----------------
  initial
  begin
    i_mclk = 1'b0;
    forever #4 i_mclk = ~i_mclk;
  end
  always @(posedge i_mclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_errors++;
      test_done();
    end
  end
  initial
  begin
    {i_rst_n, i_wr, i_rd, go, stray, i_tmr_run, i_poe_run} = 7'h0;
    i_independent_watchdog_run = 1'b1;
    {i_addr, delay, vec, i_wdata} = {8'h00, 8'h06, 8'h00, 32'h0};
    repeat (5) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    t_reset();
    t_stop();
    t_div();
    reg_wr(`LPM_OFF_STOP_A, 32'hffff_fffe);
    reg_wr(`LPM_OFF_STOP_D, 32'hffff_fbff);
    for (int m = 0; m < 4; m++)
      t_mode(m, m != 1);
    t_stray();
    t_reset_wake();
    test_done();
  end
endmodule // test_low_power_mode_controller
